/* File: design/cml_cfg.svh */
// Constants of the condition-code move and logic unit.
// What this block does
// - Condition code to data register lands in bit zero, other bits zero.
// - Data register to condition code gives one when any bit is set.
// - Status bit is written with, or ORed, ANDed, XORed with, the code.
// - Condition code is loaded with, or combined with, a status bit.
// - Selectable status bits are the eleven arithmetic flags only.
// - A transfer changes only its destination flag.
// - Negate inverts the condition code and nothing else.
// - AND writes the bitwise AND of two data registers.
// - OR writes the bitwise inclusive OR of two data registers.
// - XOR writes the bitwise exclusive OR of two data registers.
// - NOT writes the inverse of every bit of one data register.
// - Sources stay unchanged unless also the destination.
// - Logic operations set the zero flag exactly when the result is zero.
// - Logic operations set the negative flag from the result sign.
// - Logic operations clear first carry and overflow, keep other flags.
// - Every operation is decoded from one 16-bit instruction word.
// - Condition code and arithmetic flags share one status register.
// - The current condition code alone drives later branches.
`ifndef CML_CFG_SVH
`define CML_CFG_SVH
`define CML_AW          8
`define CML_OFF_INSTR   8'h00
`define CML_OFF_STAT    8'h04
`define CML_OFF_ERR     8'h08
`define CML_DSEL        3'h1
`define CML_F_DSEL      7:5
`define CML_F_DIDX      4:2
`define CML_F_ALIGN     1:0
`define CML_ALIGN_OK    2'h0
`define CML_STRB_INSTR  2'h3
`define CML_RESP_OKAY   2'h0
`define CML_RESP_DECERR 2'h3
`define CML_ST_W        12
`define CML_ST_RST      12'h000
`define CML_CC_MASK     12'h800
`define CML_B_ZERO      4'h0
`define CML_B_NEG       4'h1
`define CML_B_CF1       4'h2
`define CML_B_OVF       4'h4
`define CML_B_CC        4'hB
`define CML_SB_MAX      4'hA
`define CML_B_SIGN      31
`define CML_F_OPC       15:12
`define CML_F_DST       8:6
`define CML_F_S0        5:3
`define CML_F_S1        2:0
`define CML_F_BOP       5:4
`define CML_F_SB        3:0
`define CML_OPC_CC2D    4'h1
`define CML_OPC_D2CC    4'h2
`define CML_OPC_CC2SB   4'h3
`define CML_OPC_SB2CC   4'h4
`define CML_OPC_NEGCC   4'h5
`define CML_OPC_AND     4'h6
`define CML_OPC_OR      4'h7
`define CML_OPC_XOR     4'h8
`define CML_OPC_NOT     4'h9
`define CML_BOP_SET     2'h0
`define CML_BOP_OR      2'h1
`define CML_BOP_AND     2'h2
`define CML_BOP_XOR     2'h3
`endif

/* File: design/cml_pkg.sv */
// Types shared by the condition-code move and logic unit.
`include "cml_cfg.svh"
package cml_pkg;
	typedef enum logic [3:0] {
		OP_NONE, OP_CC2D, OP_D2CC, OP_CC2SB, OP_SB2CC,
		OP_NEGCC, OP_AND, OP_OR, OP_XOR, OP_NOT
	} cml_op_t;
	typedef enum logic [1:0] {BOP_SET, BOP_OR, BOP_AND, BOP_XOR} cml_bop_t;
	typedef struct packed {
		logic [7:0][31:0]       dreg;
		logic [`CML_ST_W-1:0]   arith_status_register;
		logic [15:0]            instr;
		logic                   illegal;
		logic                   aw_have;
		logic [`CML_AW-1:0]     aw_addr;
		logic                   w_have;
		logic [31:0]            w_data;
		logic [3:0]             w_strb;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
	} cml_state_t;
endpackage : cml_pkg

/* File: design/cml_decode.sv */
// Instruction decoder of the condition-code move and logic unit.
`timescale 1ns/10ps
`include "cml_cfg.svh"
module cml_decode
	import cml_pkg::*;
(
	// Instruction word
	input  wire logic [15:0] instr,
	// Decoded fields
	output cml_op_t          op,
	output logic [2:0]       dst,
	output logic [2:0]       s0,
	output logic [2:0]       s1,
	output logic [3:0]       sbit,
	output cml_bop_t         bop,
	output logic             legal
);
	always_comb begin
		dst  = instr[`CML_F_DST];
		s0   = instr[`CML_F_S0];
		s1   = instr[`CML_F_S1];
		sbit = instr[`CML_F_SB];
		legal = 1'b1;
		unique case (instr[`CML_F_BOP])
			`CML_BOP_SET: bop = BOP_SET;
			`CML_BOP_OR:  bop = BOP_OR;
			`CML_BOP_AND: bop = BOP_AND;
			`CML_BOP_XOR: bop = BOP_XOR;
		endcase
		unique case (instr[`CML_F_OPC])
			`CML_OPC_CC2D:  op = OP_CC2D;
			`CML_OPC_D2CC:  op = OP_D2CC;
			`CML_OPC_CC2SB: op = OP_CC2SB;
			`CML_OPC_SB2CC: op = OP_SB2CC;
			`CML_OPC_NEGCC: op = OP_NEGCC;
			`CML_OPC_AND:   op = OP_AND;
			`CML_OPC_OR:    op = OP_OR;
			`CML_OPC_XOR:   op = OP_XOR;
			`CML_OPC_NOT:   op = OP_NOT;
			default: begin
				op = OP_NONE;
				legal = 1'b0;
			end
		endcase
		// no self transfer.
		// The selector cannot name the condition code, so a self move
		// is refused here rather than left to the issuer.
		if ((op == OP_CC2SB || op == OP_SB2CC) && sbit > `CML_SB_MAX) begin
			legal = 1'b0;
		end
	end
endmodule : cml_decode

/* File: design/cml_unit.sv */
// Condition-code move and logic unit with its AXI4-Lite register slave.
`timescale 1ns/10ps
`include "cml_cfg.svh"
module cml_unit
	import cml_pkg::*;
(
	// Clock, reset and enable
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic               clk_en,
	// Write address channel
	input  wire logic [`CML_AW-1:0] awaddr,
	input  wire logic               awvalid,
	output logic                    awready,
	// Write data channel
	input  wire logic [31:0]        wdata,
	input  wire logic [3:0]         wstrb,
	input  wire logic               wvalid,
	output logic                    wready,
	// Write response channel
	output logic [1:0]              bresp,
	output logic                    bvalid,
	input  wire logic               bready,
	// Read address channel
	input  wire logic [`CML_AW-1:0] araddr,
	input  wire logic               arvalid,
	output logic                    arready,
	// Read data channel
	output logic [31:0]             rdata,
	output logic [1:0]              rresp,
	output logic                    rvalid,
	input  wire logic               rready,
	// Branch condition
	output logic                    branch_cc
);
	cml_state_t         st_r;
	cml_state_t         st_nxt;
	cml_op_t            dec_op;
	cml_bop_t           dec_bop;
	logic [2:0]         dec_dst;
	logic [2:0]         dec_s0;
	logic [2:0]         dec_s1;
	logic [3:0]         dec_sbit;
	logic               dec_legal;
	logic [31:0]        wmask;
	logic [31:0]        src0;
	logic [31:0]        src1;
	logic [31:0]        lres;
	logic               cc;
	logic               sb_val;
	logic [`CML_ST_W-1:0] sb_mask;
	logic               wr_fire;
	logic               exec;
	logic               instr_hit;
	logic               stat_hit;
	logic               err_hit;
	logic               dreg_hit;
	logic               rd_dreg;
	logic               is_logic;

	cml_decode u_dec (
		.instr (st_r.w_data[15:0]),
		.op    (dec_op),
		.dst   (dec_dst),
		.s0    (dec_s0),
		.s1    (dec_s1),
		.sbit  (dec_sbit),
		.bop   (dec_bop),
		.legal (dec_legal)
	);

	for (genvar b = 0; b < 4; b++) begin : g_lane
		assign wmask[8*b +: 8] = {8{st_r.w_strb[b]}};
	end

	function automatic logic bop_f(input logic a, input logic c,
		input cml_bop_t op);
		unique case (op)
			BOP_SET: bop_f = c;
			BOP_OR:  bop_f = a | c;
			BOP_AND: bop_f = a & c;
			BOP_XOR: bop_f = a ^ c;
		endcase
	endfunction : bop_f

	assign cc      = st_r.arith_status_register[`CML_B_CC];
	assign sb_val  = (dec_sbit <= `CML_SB_MAX) ? st_r.arith_status_register[dec_sbit] : 1'b0;
	assign sb_mask = `CML_ST_W'(1) << dec_sbit;
	assign src0    = st_r.dreg[dec_s0];
	assign src1    = st_r.dreg[dec_s1];
	assign is_logic = dec_op inside {OP_AND, OP_OR, OP_XOR, OP_NOT};

	always_comb begin
		unique case (dec_op)
			OP_AND:  lres = src0 & src1;
			OP_OR:   lres = src0 | src1;
			OP_XOR:  lres = src0 ^ src1;
			OP_NOT:  lres = ~src0;
			default: lres = 32'h0000_0000;
		endcase
	end

	assign wr_fire   = clk_en & st_r.aw_have & st_r.w_have;
	assign instr_hit = st_r.aw_addr == `CML_OFF_INSTR;
	assign stat_hit  = st_r.aw_addr == `CML_OFF_STAT;
	assign err_hit   = st_r.aw_addr == `CML_OFF_ERR;
	assign dreg_hit  = st_r.aw_addr[`CML_F_DSEL] == `CML_DSEL
		&& st_r.aw_addr[`CML_F_ALIGN] == `CML_ALIGN_OK;
	assign rd_dreg   = araddr[`CML_F_DSEL] == `CML_DSEL
		&& araddr[`CML_F_ALIGN] == `CML_ALIGN_OK;
	assign exec = wr_fire & instr_hit & dec_legal
		& (st_r.w_strb[1:0] == `CML_STRB_INSTR);

	// single issue.
	// Only one write is accepted until its response is taken, so two
	// instructions can never overlap.
	assign awready = clk_en & ~st_r.aw_have & ~st_r.bvalid;
	assign wready  = clk_en & ~st_r.w_have & ~st_r.bvalid;
	assign arready = clk_en & ~st_r.rvalid;

	always_comb begin
		st_nxt = st_r;
		if (awvalid && awready) begin
			st_nxt.aw_have = 1'b1;
			st_nxt.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			st_nxt.w_have = 1'b1;
			st_nxt.w_data = wdata;
			st_nxt.w_strb = wstrb;
		end
		if (st_r.bvalid && bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (wr_fire) begin
			st_nxt.aw_have = 1'b0;
			st_nxt.w_have  = 1'b0;
			st_nxt.bvalid  = 1'b1;
			st_nxt.bresp   = `CML_RESP_OKAY;
			if (instr_hit) begin
				st_nxt.instr = st_r.w_data[15:0];
				if (st_r.w_strb[1:0] == `CML_STRB_INSTR && !dec_legal) begin
					st_nxt.illegal = 1'b1;
				end
			end else if (stat_hit) begin
				st_nxt.arith_status_register = `CML_ST_W'((32'(st_r.arith_status_register) & ~wmask)
					| (st_r.w_data & wmask));
			end else if (err_hit) begin
				st_nxt.illegal = 1'b0;
			end else if (dreg_hit) begin
				st_nxt.dreg[st_r.aw_addr[`CML_F_DIDX]] =
					(st_r.dreg[st_r.aw_addr[`CML_F_DIDX]] & ~wmask)
					| (st_r.w_data & wmask);
			end else begin
				st_nxt.bresp = `CML_RESP_DECERR;
			end
		end
		// joint commit.
		// Register and flag results go to st_nxt together and so land
		// on the same edge as the write response.
		if (exec) begin
			unique case (dec_op)
				OP_CC2D: st_nxt.dreg[dec_dst] = {31'h0000_0000, cc};
				OP_D2CC: st_nxt.arith_status_register[`CML_B_CC] = |src0;
				OP_CC2SB: st_nxt.arith_status_register[dec_sbit] = bop_f(sb_val, cc, dec_bop);
				OP_SB2CC: st_nxt.arith_status_register[`CML_B_CC] = bop_f(cc, sb_val, dec_bop);
				OP_NEGCC: st_nxt.arith_status_register[`CML_B_CC] = ~cc;
				OP_AND, OP_OR, OP_XOR, OP_NOT: begin
					st_nxt.dreg[dec_dst] = lres;
					st_nxt.arith_status_register[`CML_B_ZERO] = lres == 32'h0000_0000;
					st_nxt.arith_status_register[`CML_B_NEG] = lres[`CML_B_SIGN];
					st_nxt.arith_status_register[`CML_B_CF1] = 1'b0;
					st_nxt.arith_status_register[`CML_B_OVF] = 1'b0;
				end
				OP_NONE: st_nxt.illegal = st_r.illegal;
			endcase
		end
		if (st_r.rvalid && rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp  = `CML_RESP_OKAY;
			if (araddr == `CML_OFF_INSTR) begin
				st_nxt.rdata = {16'h0000, st_r.instr};
			end else if (araddr == `CML_OFF_STAT) begin
				st_nxt.rdata = 32'(st_r.arith_status_register);
			end else if (araddr == `CML_OFF_ERR) begin
				st_nxt.rdata = {31'h0000_0000, st_r.illegal};
			end else if (rd_dreg) begin
				st_nxt.rdata = st_r.dreg[araddr[`CML_F_DIDX]];
			end else begin
				st_nxt.rdata = 32'h0000_0000;
				st_nxt.rresp = `CML_RESP_DECERR;
			end
		end
	end

	// The reset value is a constant; the enable freezes everything else.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r       <= '0;
			st_r.arith_status_register <= `CML_ST_RST;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign bvalid = st_r.bvalid;
	assign bresp  = st_r.bresp;
	assign rvalid = st_r.rvalid;
	assign rdata  = st_r.rdata;
	assign rresp  = st_r.rresp;
	assign branch_cc = cc;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	cc_to_dreg_a: assert property (
		exec && dec_op == OP_CC2D
		|=> st_r.dreg[$past(dec_dst)] == {31'h0000_0000, $past(cc)})
		else $error("Code move to register is not zero-extended.");

	dreg_to_cc_a: assert property (
		exec && dec_op == OP_D2CC
		|=> branch_cc == ($past(src0) != 32'h0000_0000))
		else $error("Code does not reflect a non-zero register.");

	sbit_write_a: assert property (
		exec && dec_op == OP_CC2SB
		|=> st_r.arith_status_register[$past(dec_sbit)]
			== bop_f($past(sb_val), $past(cc), $past(dec_bop)))
		else $error("Status bit write gives the wrong value.");

	cc_load_a: assert property (
		exec && dec_op == OP_SB2CC
		|=> branch_cc == bop_f($past(cc), $past(sb_val), $past(dec_bop)))
		else $error("Code load from status bit is wrong.");

	one_flag_a: assert property (
		exec && dec_op == OP_CC2SB
		|=> ((st_r.arith_status_register ^ $past(st_r.arith_status_register)) & ~$past(sb_mask)) == '0)
		else $error("Transfer changed a flag other than its target.");

	negate_cc_a: assert property (
		exec && dec_op == OP_NEGCC
		|=> st_r.arith_status_register == ($past(st_r.arith_status_register) ^ `CML_CC_MASK))
		else $error("Negate did not toggle only the code.");

	and_result_a: assert property (
		exec && dec_op == OP_AND
		|=> st_r.dreg[$past(dec_dst)] == ($past(src0) & $past(src1)))
		else $error("AND result is wrong.");

	not_result_a: assert property (
		exec && dec_op == OP_NOT
		|=> st_r.dreg[$past(dec_dst)] == ~$past(src0))
		else $error("One's complement result is wrong.");

	source_kept_a: assert property (
		exec && is_logic && dec_dst != dec_s0
		|=> st_r.dreg[$past(dec_s0)] == $past(src0))
		else $error("Source register changed.");

	logic_flags_a: assert property (
		exec && is_logic
		|=> st_r.arith_status_register[`CML_B_ZERO]
				== (st_r.dreg[$past(dec_dst)] == 32'h0000_0000)
			&& st_r.arith_status_register[`CML_B_NEG]
				== st_r.dreg[$past(dec_dst)][`CML_B_SIGN]
			&& !st_r.arith_status_register[`CML_B_CF1] && !st_r.arith_status_register[`CML_B_OVF])
		else $error("Logic operation flags are wrong.");

	joint_commit_a: assert property (
		exec && clk_en |=> bvalid && st_r.instr == $past(st_r.w_data[15:0]))
		else $error("Result committed apart from its response.");

	read_hold_a: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("Read data dropped before it was taken.");
endmodule : cml_unit

/* File: verification/cml_issuer.sv */
// Issuing master that hands instructions and register traffic to the unit.
`timescale 1ns/10ps
`include "cml_cfg.svh"
module cml_issuer (
	// Clock
	input  wire logic               aclk,
	// Write channels
	output logic [`CML_AW-1:0]      awaddr,
	output logic                    awvalid,
	input  wire logic               awready,
	output logic [31:0]             wdata,
	output logic [3:0]              wstrb,
	output logic                    wvalid,
	input  wire logic               wready,
	input  wire logic [1:0]         bresp,
	input  wire logic               bvalid,
	output logic                    bready,
	// Read channels
	output logic [`CML_AW-1:0]      araddr,
	output logic                    arvalid,
	input  wire logic               arready,
	input  wire logic [31:0]        rdata,
	input  wire logic [1:0]         rresp,
	input  wire logic               rvalid,
	output logic                    rready
);
	// Cycles a write or read response waits before it is accepted, so that
	// the unit must hold its answer.
	int lag = 0;
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr  <= a;
		awvalid <= 1'h1;
		wdata   <= d;
		wstrb   <= s;
		wvalid  <= 1'h1;
		bready  <= (lag == 0);
		forever begin
			@(posedge aclk);
			n++;
			// Released payload is scrambled so nothing relies on stale values.
			if (awvalid && awready) begin
				awvalid <= 1'h0;
				awaddr  <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'h0;
				wdata  <= ~d;
			end
			if (bready && bvalid) begin
				r = bresp;
				bready <= 1'h0;
				break;
			end
			if (n >= lag)
				bready <= 1'h1;
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'h1;
		rready  <= (lag == 0);
		forever begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) begin
				arvalid <= 1'h0;
				araddr  <= ~a;
			end
			if (rvalid && rready) begin
				d = rdata;
				r = rresp;
				rready <= 1'h0;
				break;
			end
			if (n >= lag)
				rready <= 1'h1;
		end
	endtask : rd
endmodule : cml_issuer

/* File: verification/cml_unit_tb.sv */
// Self-checking bench of the condition-code move and logic unit.
`timescale 1ns/10ps
`include "cml_cfg.svh"
module cml_unit_tb;
	logic               aclk, aresetn, clk_en, branch_cc;
	logic [`CML_AW-1:0] awaddr, araddr;
	logic               awvalid, awready, wvalid, wready, bvalid, bready;
	logic               arvalid, arready, rvalid, rready;
	logic [31:0]        wdata, rdata;
	logic [3:0]         wstrb;
	logic [1:0]         bresp, rresp;
	logic [31:0]        er [8];
	logic [11:0]        es;
	int                 n_fail, num_checks;
	int                 cyc = 0;

	cml_unit u_cml_unit (.aclk, .aresetn, .clk_en, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.branch_cc);
	cml_issuer u_cml_issuer (.aclk, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

	initial aclk = 1'h0;
	always #20 aclk = ~aclk;

	// The whole run needs under two thousand cycles; this cuts a hang short.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic put(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		u_cml_issuer.wr(a, d, 4'hF, r);
		chk(r, `CML_RESP_OKAY);
	endtask : put

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		u_cml_issuer.rd(a, d, r);
		chk(d, exp);
		chk(r, `CML_RESP_OKAY);
	endtask : rdc

	task automatic setr(input int i, input logic [31:0] v);
		er[i] = v;
		put(8'h20 + 8'(4 * i), v);
	endtask : setr

	task automatic sets(input logic [11:0] v);
		es = v;
		put(`CML_OFF_STAT, {20'h0, v});
	endtask : sets

	function automatic logic bop(input logic x, input logic c,
		input logic [1:0] k);
		case (k)
		2'h0: return c;
		2'h1: return x | c;
		2'h2: return x & c;
		default: return x ^ c;
		endcase
	endfunction : bop

	// Expected effect of one legal instruction, then issue it.
	task automatic op(input logic [15:0] ins);
		logic [31:0] a, b, y;
		a = er[ins[5:3]];
		b = er[ins[2:0]];
		case (ins[15:12])
		4'h1: er[ins[8:6]] = {31'h0, es[`CML_B_CC]};
		4'h2: es[`CML_B_CC] = |a;
		4'h3: es[ins[3:0]] = bop(es[ins[3:0]], es[`CML_B_CC], ins[5:4]);
		4'h4: es[`CML_B_CC] = bop(es[`CML_B_CC], es[ins[3:0]], ins[5:4]);
		4'h5: es[`CML_B_CC] = ~es[`CML_B_CC];
		default: begin
			y = (ins[15:12] == 4'h6) ? (a & b) : (ins[15:12] == 4'h7) ?
				(a | b) : (ins[15:12] == 4'h8) ? (a ^ b) : ~a;
			er[ins[8:6]] = y;
			es[`CML_B_ZERO] = (y == 32'h0);
			es[`CML_B_NEG] = y[`CML_B_SIGN];
			es[`CML_B_CF1] = 1'h0;
			es[`CML_B_OVF] = 1'h0;
		end
		endcase
		put(`CML_OFF_INSTR, {16'h0, ins});
	endtask : op

	task automatic all_chk();
		for (int i = 0; i < 8; i++)
			rdc(8'h20 + 8'(4 * i), er[i]);
		rdc(`CML_OFF_STAT, {20'h0, es});
		chk(branch_cc, es[`CML_B_CC]);
	endtask : all_chk

	task automatic t_cc();
		logic [15:0] seq [6] = '{16'h10C0, 16'h2000, 16'h2018, 16'h2000,
			16'h1180, 16'h2028};
		sets(12'h800);
		setr(3, 32'hFFFF_FFFF);
		setr(5, 32'h8000_0000);
		setr(6, 32'hFFFF_FFFF);
		foreach (seq[i]) begin
			op(seq[i]);
			all_chk();
		end
	endtask : t_cc

	task automatic t_statbit();
		for (int k = 0; k < 4; k++) begin
			sets({k[0], 11'h55A ^ {11{k[1]}}});
			for (int sb = 0; sb <= 10; sb++)
				for (int o = 3; o <= 4; o++) begin
					op(16'h5000);
					op({o[3:0], 6'h0, k[1:0], sb[3:0]});
					rdc(`CML_OFF_STAT, {20'h0, es});
					chk(branch_cc, es[`CML_B_CC]);
				end
		end
	endtask : t_statbit

	task automatic t_logic();
		logic [15:0] seq [7] = '{16'h60CA, 16'h6148, 16'h704A, 16'h8092,
			16'h81A0, 16'h91F8, 16'h9000};
		setr(0, 32'h0);
		setr(1, 32'hF0F0_1234);
		setr(2, 32'h0F0F_1234);
		setr(4, 32'h8000_0000);
		setr(7, 32'hFFFF_FFFF);
		foreach (seq[i]) begin
			sets(12'hFFF);
			op(seq[i]);
			all_chk();
		end
	endtask : t_logic

	task automatic t_refuse();
		logic [15:0] bad [3] = '{16'hF000, 16'h300B, 16'h400B};
		logic [31:0] d;
		logic [1:0]  r;
		// deliberately broken: an undefined opcode, then the condition code on both sides.
		foreach (bad[i]) begin
			put(`CML_OFF_INSTR, {16'h0, bad[i]});
			rdc(`CML_OFF_ERR, 32'h1);
			all_chk();
			put(`CML_OFF_ERR, 32'h0);
			rdc(`CML_OFF_ERR, 32'h0);
		end
		u_cml_issuer.wr(`CML_OFF_INSTR, 32'h5000, 4'h1, r);
		chk(r, `CML_RESP_OKAY);
		rdc(`CML_OFF_INSTR, 32'h5000);
		all_chk();
		// Byte strobes: only lanes 0 and 2 of the last register land.
		u_cml_issuer.wr(8'h3C, 32'h1234_5678, 4'h5, r);
		chk(r, `CML_RESP_OKAY);
		er[7] = (er[7] & 32'hFF00_FF00) | 32'h0034_0078;
		all_chk();
		u_cml_issuer.lag = 3;
		u_cml_issuer.wr(8'h10, 32'h1, 4'hF, r);
		chk(r, `CML_RESP_DECERR);
		// A stalled read must keep its data until it is taken.
		u_cml_issuer.rd(8'h10, d, r);
		u_cml_issuer.lag = 0;
		chk(d, 32'h0);
		chk(r, `CML_RESP_DECERR);
		clk_en <= 1'h0;
		@(negedge aclk);
		chk(awready, 1'h0);
		chk(arready, 1'h0);
		@(posedge aclk);
		clk_en <= 1'h1;
	endtask : t_refuse

	initial begin
		aresetn = 1'h0;
		clk_en = 1'h1;
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		foreach (er[i])
			er[i] = 32'h0;
		es = 12'h0;
		all_chk();
		t_cc();
		t_statbit();
		t_logic();
		t_refuse();
		finish_test();
	end
endmodule : cml_unit_tb
